// ==== hw/bhci_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the top module
`ifndef BHCI_REGS_SVH
`define BHCI_REGS_SVH
`define BHCI_ADDR_THRESH   4'h0
`define BHCI_ADDR_STATUS   4'h1
`define BHCI_ADDR_ENABLE   4'h2
`define BHCI_ADDR_CLEAR    4'h3
`define BHCI_ADDR_COUNT    4'h4
`define BHCI_HI_FIELD_LSB  6
`define BHCI_FIELD_W       6
`define BHCI_THRESH_RST    12'h000
`define BHCI_ENABLE_RST    5'h00
`define BHCI_OP_RREG       3'h0
`define BHCI_OP_WREG       3'h1
`define BHCI_OP_RFIFO      3'h3
`define BHCI_OP_WFIFO      3'h5
`define BHCI_FULL_BURST    6'h20
`define BHCI_CLK_HZ        200000000
`define BHCI_BAUD_LO_BPS   9600
`define BHCI_BAUD_HI_BPS   115200
`define BHCI_BAUD_MIN_BPS  2400
`define BHCI_BAUD_MAX_BPS  256000
`endif

// ==== hw/bhci_pkg.sv ====
// Types shared by the host control interface design
// Assumes the register header is on the include path
package bhci_pkg;
  typedef logic [7:0] bhci_byte_t;            // One transferred byte
  // Receive FIFO condition flags, bit order as in status register
  typedef struct packed {
    logic not_empty;                          // Bit 4
    logic overflow;                           // Bit 3
    logic over_thr;                           // Bit 2
    logic empty;                              // Bit 1
    logic under_thr;                          // Bit 0
  } bhci_irq_t;
  // SPI byte-level command state
  typedef enum logic [2:0] {
    BHCI_SP_CMD   = 3'b000,
    BHCI_SP_RREG  = 3'b001,
    BHCI_SP_WREG  = 3'b010,
    BHCI_SP_RFIFO = 3'b011,
    BHCI_SP_WFIFO = 3'b100,
    BHCI_SP_SKIP  = 3'b101
  } bhci_spi_state_t;
endpackage : bhci_pkg

// ==== hw/bhci_top.sv ====
// Host control interface: strap-selected SPI slave or UART transport, with FIFOs
// Assumes all pins are asynchronous to ref_clk; core side runs on ref_clk
`timescale 1ns/100ps
`include "bhci_regs.svh"

module bhci_fifo #(
  parameter int WIDTH = 8,                    // Word width
  parameter int DEPTH = 32                    // Word count
) (
  input  wire logic             ref_clk,      // Clock
  input  wire logic             sys_rst,      // Synchronous reset
  input  wire logic             clk_en,       // Freeze when low
  input  wire logic [WIDTH-1:0] in_data,      // Write word
  input  wire logic             in_valid,     // Write request
  output logic                  in_ready,     // Room available
  output logic      [WIDTH-1:0] out_data,     // Head word
  output logic                  out_valid,    // Head valid
  input  wire logic             out_ready,    // Pop request
  output logic [$clog2(DEPTH):0] level        // Fill level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];              // Storage
  logic [AW-1:0]    wr_idx;                   // Write index
  logic [AW-1:0]    rd_idx;                   // Read index
  logic             push;                     // Accepted write
  logic             pop;                      // Accepted read
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;
  // Storage write
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && push)
      mem[wr_idx] <= in_data;
  end
  // Pointers and level
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      level  <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      if (push && !pop)
        level <= level + 1'b1;
      else if (pop && !push)
        level <= level - 1'b1;
    end
  end
endmodule : bhci_fifo

module bhci_top import bhci_pkg::*; #(
  parameter int SPI_DEPTH   = 32,                              // SPI FIFO depth
  parameter int UART_DEPTH  = 16,                              // UART FIFO depth
  parameter int BAUD_DIV_LO = `BHCI_CLK_HZ / `BHCI_BAUD_LO_BPS, // 9600 divisor
  parameter int BAUD_DIV_HI = `BHCI_CLK_HZ / `BHCI_BAUD_HI_BPS  // 115200 divisor
) (
  input  wire logic       ref_clk,                // 200 MHz clock
  input  wire logic       sys_rst,                // Reset, active high
  input  wire logic       clk_en,                 // Freeze when low
  input  wire logic       transport_select_strap, // High selects SPI
  input  wire logic       two_wire_clock_strap,   // UART baud strap
  input  wire logic       wake_request_input,     // Low requests sleep
  input  wire logic       power_off_input,        // Low powers down
  input  wire logic       cs_cts_in,              // SPI select or UART clear
  input  wire logic       clk_rts_in,             // SPI clock pin input
  output logic            clk_rts_out,            // UART request output
  output logic            clk_rts_oe,             // Drive enable, UART only
  input  wire logic       mosi_rxd_in,            // SPI data in or UART rx
  output logic            miso_txd_out,           // SPI data out or UART tx
  output logic            spi_irq_out,            // SPI interrupt request
  output logic            data_ready_irq_out,     // Low when data ready
  output logic            state_out,              // High awake, low asleep
  input  wire logic [16:0] baud_div_in,           // Core baud divisor
  input  wire logic       baud_div_load,          // Load divisor pulse
  output bhci_byte_t      host_rx_data,           // Byte from host
  output logic            host_rx_valid,          // Byte available
  input  wire logic       host_rx_ready,          // Core takes byte
  input  wire bhci_byte_t host_tx_data,           // Byte to host
  input  wire logic       host_tx_valid,          // Core offers byte
  output logic            host_tx_ready           // Room for byte
);
  logic [1:0] sync_cs, sync_sck, sync_din, sync_strap, sync_baud, sync_wake, sync_pdn;
  logic       cs_q, sck_q;                         // Previous synced levels
  logic       strap_done;                          // Straps captured
  logic       spi_mode;                            // SPI transport chosen
  logic       powered_down;                        // Power-down latch
  logic       run;                                 // Clock gate for logic
  logic       sck_rise, sck_fall, cs_fall;         // Link events
  logic       cs_low;                              // Frame active
  logic [11:0] thresh;                             // Threshold register
  logic [4:0]  irq_en;                             // Enable register
  bhci_irq_t   irq_flag;                           // Status register
  bhci_irq_t   irq_cond;                           // Live conditions
  logic [4:0]  clr_pulse;                          // Clear strobe
  logic [5:0]  rx_lvl, tx_lvl;                     // SPI FIFO levels
  logic        rx_overflow;                        // Write to full RX
  assign run      = clk_en & ~powered_down;
  assign sck_rise = sync_sck[1] & ~sck_q;
  assign sck_fall = ~sync_sck[1] & sck_q;
  assign cs_low   = ~sync_cs[1];
  assign cs_fall  = cs_q & ~sync_cs[1];

  // Two-flop synchronisers for every pin input
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync_cs <= 2'h3; sync_sck <= 2'h0; sync_din <= 2'h3; sync_strap <= 2'h0;
      sync_baud <= 2'h0; sync_wake <= 2'h3; sync_pdn <= 2'h3; cs_q <= 1'b1; sck_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_cs    <= {sync_cs[0], cs_cts_in};
      sync_sck   <= {sync_sck[0], clk_rts_in};
      sync_din   <= {sync_din[0], mosi_rxd_in};
      sync_strap <= {sync_strap[0], transport_select_strap};
      sync_baud  <= {sync_baud[0], two_wire_clock_strap};
      sync_wake  <= {sync_wake[0], wake_request_input};
      sync_pdn   <= {sync_pdn[0], power_off_input};
      cs_q       <= sync_cs[1];
      sck_q      <= sync_sck[1];
    end
  end

  // Strap capture once synchronisers have filled after reset
  logic [1:0] strap_wait;                           // Sync fill counter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      spi_mode   <= 1'b1;
    end
    else if (clk_en && !strap_done)
    begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2)
      begin
        strap_done <= 1'b1;
        spi_mode   <= sync_strap[1];
      end
    end
  end

  // Power-down latch, left only by reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      powered_down <= 1'b0;
    else if (clk_en && strap_done && !sync_pdn[1])
      powered_down <= 1'b1;
  end

  // Sleep state: wake pin level, or chip-select activity while asleep
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_out <= 1'b1;
    else if (run)
      state_out <= sync_wake[1] | (spi_mode & (cs_fall | cs_low));
  end

  // FIFO instances: SPI pair and UART pair
  bhci_byte_t s_rx_in, u_rx_in, s_rx_out, u_rx_out, s_tx_out, u_tx_out, spi_tx_byte;
  logic s_rx_push, u_rx_push, s_rx_rdy, u_rx_rdy, s_rx_v, u_rx_v, s_tx_v, u_tx_v;
  logic s_tx_pop, u_tx_pop, s_tx_rdy, u_tx_rdy;
  logic [$clog2(SPI_DEPTH):0]  s_rx_lvl, s_tx_lvl;
  logic [$clog2(UART_DEPTH):0] u_rx_lvl, u_tx_lvl;
  bhci_fifo #(.WIDTH(8), .DEPTH(SPI_DEPTH)) u_spi_rx (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(run), .in_data(s_rx_in),
    .in_valid(s_rx_push), .in_ready(s_rx_rdy), .out_data(s_rx_out), .out_valid(s_rx_v),
    .out_ready(spi_mode & host_rx_ready), .level(s_rx_lvl));
  bhci_fifo #(.WIDTH(8), .DEPTH(SPI_DEPTH)) u_spi_tx (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(run), .in_data(host_tx_data),
    .in_valid(spi_mode & host_tx_valid), .in_ready(s_tx_rdy), .out_data(s_tx_out),
    .out_valid(s_tx_v), .out_ready(s_tx_pop), .level(s_tx_lvl));
  bhci_fifo #(.WIDTH(8), .DEPTH(UART_DEPTH)) u_uart_rx (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(run), .in_data(u_rx_in),
    .in_valid(u_rx_push), .in_ready(u_rx_rdy), .out_data(u_rx_out), .out_valid(u_rx_v),
    .out_ready(~spi_mode & host_rx_ready), .level(u_rx_lvl));
  bhci_fifo #(.WIDTH(8), .DEPTH(UART_DEPTH)) u_uart_tx (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(run), .in_data(host_tx_data),
    .in_valid(~spi_mode & host_tx_valid), .in_ready(u_tx_rdy), .out_data(u_tx_out),
    .out_valid(u_tx_v), .out_ready(u_tx_pop), .level(u_tx_lvl));
  // Core side follows the chosen transport
  assign host_rx_data  = spi_mode ? s_rx_out : u_rx_out;
  assign host_rx_valid = spi_mode ? s_rx_v : u_rx_v;
  assign host_tx_ready = run & (spi_mode ? s_tx_rdy : u_tx_rdy);
  assign rx_lvl = 6'(s_rx_lvl);
  assign tx_lvl = 6'(s_tx_lvl);

  // Register read decode, used for both bytes of a read
  function automatic logic [11:0] reg_read(input logic [3:0] addr);
    unique case (addr)
      `BHCI_ADDR_THRESH: reg_read = thresh;
      `BHCI_ADDR_STATUS: reg_read = {7'h00, irq_flag};
      `BHCI_ADDR_ENABLE: reg_read = {7'h00, irq_en};
      `BHCI_ADDR_COUNT:  reg_read = {rx_lvl, tx_lvl};
      default:           reg_read = 12'h000;                      // Clear and unmapped
    endcase
  endfunction : reg_read

  // SPI slave: shift on synced edges, mode 0, MSB first
  bhci_spi_state_t sp_state;                        // Command state
  logic [2:0]  bit_cnt;                             // Bit within byte
  bhci_byte_t  rx_shift, tx_shift;                  // Shift registers
  logic [3:0]  reg_addr;                            // Addressed register
  logic        byte_hi;                             // Second byte of field
  logic [7:0]  wr_lo;                               // Held low write byte
  logic [5:0]  remain;                              // FIFO bytes left
  bhci_byte_t  got;                                 // Completed byte
  logic        byte_done;                           // Byte completes now
  logic [11:0] cmd_rd;                              // Register named by command byte
  logic [11:0] hold_rd;                             // Register held for second byte
  assign cmd_rd  = reg_read(got[4:1]);
  assign hold_rd = reg_read(reg_addr);
  assign got       = {rx_shift[6:0], sync_din[1]};
  assign byte_done = spi_mode & cs_low & sck_rise & (bit_cnt == 3'h7);
  assign s_rx_in   = got;
  assign s_rx_push = byte_done & (sp_state == BHCI_SP_WFIFO);
  assign s_tx_pop  = byte_done & s_tx_v &
                     ((sp_state == BHCI_SP_RFIFO && remain > 6'h1) ||
                      (sp_state == BHCI_SP_CMD && got[7:5] == `BHCI_OP_RFIFO));
  assign spi_tx_byte = s_tx_v ? s_tx_out : 8'h00;   // Empty FIFO sends zeros
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sp_state <= BHCI_SP_CMD; bit_cnt <= 3'h0; rx_shift <= 8'h00; tx_shift <= 8'h00;
      reg_addr <= 4'h0; byte_hi <= 1'b0; wr_lo <= 8'h00; remain <= 6'h00;
    end
    else if (run && spi_mode)
    begin
      if (!cs_low)
      begin
        sp_state <= BHCI_SP_CMD;                    // Frame end resets
        bit_cnt  <= 3'h0;
        tx_shift <= 8'h00;
      end
      else if (sck_rise)
      begin
        rx_shift <= got;                            // Sample on rising edge
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          tx_shift <= 8'h00;
          unique case (sp_state)
            BHCI_SP_CMD:
            begin
              byte_hi <= 1'b0;
              remain  <= (got[4:0] == 5'h00) ? `BHCI_FULL_BURST : {1'b0, got[4:0]};
              reg_addr <= got[4:1];
              if (got[7:5] == `BHCI_OP_RREG && got[0])
              begin
                sp_state <= BHCI_SP_RREG;
                tx_shift <= cmd_rd[7:0];                            // Low byte first
              end
              else if (got[7:5] == `BHCI_OP_WREG && got[0])
                sp_state <= BHCI_SP_WREG;
              else if (got[7:5] == `BHCI_OP_RFIFO)
              begin
                sp_state <= BHCI_SP_RFIFO;
                tx_shift <= spi_tx_byte;
              end
              else if (got[7:5] == `BHCI_OP_WFIFO)
                sp_state <= BHCI_SP_WFIFO;
              else
                sp_state <= BHCI_SP_SKIP;           // Unknown command ignored
            end
            BHCI_SP_RREG:
            begin
              byte_hi <= 1'b1;
              if (!byte_hi)
                tx_shift <= {4'h0, hold_rd[11:8]};
              else
                sp_state <= BHCI_SP_SKIP;
            end
            BHCI_SP_WREG:
            begin
              byte_hi <= 1'b1;
              wr_lo   <= got;
              if (byte_hi)
                sp_state <= BHCI_SP_SKIP;
            end
            BHCI_SP_RFIFO, BHCI_SP_WFIFO:
            begin
              remain <= remain - 6'h1;
              if (sp_state == BHCI_SP_RFIFO && remain > 6'h1)
                tx_shift <= spi_tx_byte;
              if (remain == 6'h1)
                sp_state <= BHCI_SP_SKIP;
            end
            BHCI_SP_SKIP: sp_state <= BHCI_SP_SKIP;
          endcase
        end
      end
      else if (sck_fall && bit_cnt != 3'h0)
        tx_shift <= {tx_shift[6:0], 1'b0};          // Shift out on falling edge
    end
  end

  // Register writes and clear strobe, on the completed high byte
  logic wr_commit;                                  // Second write byte done
  assign wr_commit = byte_done & (sp_state == BHCI_SP_WREG) & byte_hi;
  assign clr_pulse = (wr_commit && reg_addr == `BHCI_ADDR_CLEAR) ? wr_lo[4:0] : 5'h00;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      thresh <= `BHCI_THRESH_RST;
      irq_en <= `BHCI_ENABLE_RST;
    end
    else if (run && wr_commit)
    begin
      if (reg_addr == `BHCI_ADDR_THRESH)
        thresh <= {got[3:0], wr_lo};
      if (reg_addr == `BHCI_ADDR_ENABLE)
        irq_en <= wr_lo[4:0];
    end
  end

  // Receive FIFO conditions and sticky status; a set beats a clear
  assign rx_overflow = s_rx_push & ~s_rx_rdy;
  assign irq_cond = '{not_empty: (rx_lvl != 6'h00), overflow: rx_overflow,
                      over_thr: (rx_lvl > thresh[5:0]), empty: (rx_lvl == 6'h00),
                      under_thr: (rx_lvl < thresh[5:0])};
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      irq_flag <= '0;
    else if (run)
      irq_flag <= irq_cond | (irq_flag & ~clr_pulse);
  end

  // UART: baud divisor from strap, replaceable by the core
  logic [16:0] baud_div;                            // Bit period in clocks
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      baud_div <= 17'(BAUD_DIV_LO);
    else if (clk_en && strap_done && !spi_mode && baud_div_load)
      baud_div <= baud_div_in;
    else if (clk_en && !strap_done)
      baud_div <= sync_baud[1] ? 17'(BAUD_DIV_HI) : 17'(BAUD_DIV_LO);
  end

  // UART receiver, 8 data bits, mid-bit sampling
  logic [16:0] rx_tick;                             // Bit timer
  logic [3:0]  rx_bit;                              // 0 idle, 1 start, 2..9 data
  bhci_byte_t  rx_sh;                               // Data shift
  assign u_rx_in   = rx_sh;
  assign u_rx_push = ~spi_mode & (rx_bit == 4'ha) & (rx_tick == 17'h0) & sync_din[1];
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_tick <= 17'h0; rx_bit <= 4'h0; rx_sh <= 8'h00;
    end
    else if (run && !spi_mode)
    begin
      if (rx_bit == 4'h0)
      begin
        if (!sync_din[1])
        begin
          rx_bit  <= 4'h1;
          rx_tick <= {1'b0, baud_div[16:1]};        // Half bit to mid start
        end
      end
      else if (rx_tick != 17'h0)
        rx_tick <= rx_tick - 17'h1;
      else
      begin
        rx_tick <= baud_div - 17'h1;
        if (rx_bit == 4'h1 && sync_din[1])
          rx_bit <= 4'h0;                           // False start
        else if (rx_bit == 4'ha)
          rx_bit <= 4'h0;                           // Stop bit, byte pushed if high
        else
        begin
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit != 4'h1)
            rx_sh <= {sync_din[1], rx_sh[7:1]};     // LSB first on the line
        end
      end
    end
  end

  // UART transmitter, waits for clear-to-send (low) between characters
  logic [16:0] tx_tick;                             // Bit timer
  logic [3:0]  tx_bit;                              // Bits left
  logic [9:0]  tx_sh;                               // Stop, data, start
  assign u_tx_pop = ~spi_mode & run & (tx_bit == 4'h0) & u_tx_v & ~sync_cs[1];
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tx_tick <= 17'h0; tx_bit <= 4'h0; tx_sh <= 10'h3ff;
    end
    else if (run && !spi_mode)
    begin
      if (u_tx_pop)
      begin
        tx_sh   <= {1'b1, u_tx_out, 1'b0};          // Raw byte, no command
        tx_bit  <= 4'ha;
        tx_tick <= baud_div - 17'h1;
      end
      else if (tx_bit != 4'h0)
      begin
        if (tx_tick != 17'h0)
          tx_tick <= tx_tick - 17'h1;
        else
        begin
          tx_tick <= baud_div - 17'h1;
          tx_bit  <= tx_bit - 4'h1;
          tx_sh   <= {1'b1, tx_sh[9:1]};
        end
      end
    end
  end

  // Registered pin outputs, muxed by transport
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      miso_txd_out <= 1'b1; clk_rts_out <= 1'b1; clk_rts_oe <= 1'b0;
      spi_irq_out <= 1'b0; data_ready_irq_out <= 1'b1;
    end
    else if (run)
    begin
      miso_txd_out <= spi_mode ? tx_shift[7] : tx_sh[0];
      clk_rts_out  <= ~(u_rx_rdy & (u_rx_lvl < 5'(UART_DEPTH - 1)));    // Low: send
      clk_rts_oe   <= strap_done & ~spi_mode;
      spi_irq_out  <= spi_mode & (|(irq_flag & irq_en));
      data_ready_irq_out <= ~(spi_mode ? s_tx_v : u_tx_v);
    end
  end
endmodule : bhci_top

// ==== verification/bhci_props.sv ====
// Checker for the host control interface pins, ref_clk domain
// Assumes binding to bhci_top; the strap changes only under reset
`timescale 1ns/100ps
module bhci_props (
  input wire logic ref_clk,                // Clock
  input wire logic sys_rst,                // Reset, active high
  input wire logic transport_select_strap, // Transport strap
  input wire logic wake_request_input,     // Wake pin
  input wire logic power_off_input,        // Power-off pin
  input wire logic cs_cts_in,              // Select, active low
  input wire logic clk_rts_oe,             // Request pin enable
  input wire logic spi_irq_out,            // SPI interrupt
  input wire logic data_ready_irq_out,     // Data ready, low
  input wire logic state_out,              // Awake indicator
  input wire logic host_rx_valid,          // Host byte waiting
  input wire logic host_tx_valid,          // Core offers byte
  input wire logic host_tx_ready           // Room for byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_oe_off_spi: assert property (transport_select_strap |-> !clk_rts_oe) else $error("oe on");
  a_wake_state: assert property (disable iff (sys_rst || !power_off_input)
    $rose(wake_request_input) |-> ##[1:5] state_out) else $error("no wake");
  a_sleep_state: assert property (disable iff (sys_rst || !power_off_input)
    (!wake_request_input && cs_cts_in) [*6] |-> !state_out) else $error("no sleep");
  a_select_wake: assert property (disable iff (sys_rst || !power_off_input)
    !wake_request_input && $fell(cs_cts_in) |-> ##[1:5] state_out) else $error("no cs wake");
  a_push_ready: assert property (host_tx_valid && host_tx_ready |-> ##[1:3] !data_ready_irq_out)
    else $error("ready late");
  a_ready_drain: assert property ($rose(data_ready_irq_out) |-> !cs_cts_in) else $error("drain");
  a_rx_from_spi: assert property ($rose(host_rx_valid) |-> !cs_cts_in) else $error("rx");
  a_pdn_freeze: assert property (!power_off_input && !$past(power_off_input, 4)
    |-> $stable(state_out) && $stable(data_ready_irq_out)) else $error("not frozen");
  c_irq: cover property ($rose(spi_irq_out));
  c_ready: cover property ($fell(data_ready_irq_out));
  c_sleep: cover property ($fell(state_out));
endmodule : bhci_props
bind bhci_top bhci_props u_props (.ref_clk, .sys_rst, .transport_select_strap, .wake_request_input,
  .power_off_input, .cs_cts_in, .clk_rts_oe, .spi_irq_out, .data_ready_irq_out, .state_out,
  .host_rx_valid, .host_tx_valid, .host_tx_ready);

// ==== verification/bhci_host_spi.sv ====
// SPI host model: mode 0 master on a 125 ns link clock
// Assumes the bench calls one task at a time
`timescale 1ns/100ps
module bhci_host_spi import bhci_pkg::*; (
  output logic      cs_n = 1'b1, // Select, active low
  output logic      sclk = 1'b0, // Link clock, still between frames
  output logic      mosi = 1'b1, // Data to device
  input  wire logic miso         // Data from device
);
  // Select, then half a period before the first edge
  task open_f;
    cs_n = 1'b0;
    #62.5;
  endtask : open_f
  // Release on a byte boundary; released data flips
  task close_f;
    #62.5;
    cs_n = 1'b1;
    mosi = ~mosi;
    #250;
  endtask : close_f
  // One byte MSB first, sampled on the rise, 8 MHz
  task xb(input bhci_byte_t o, output bhci_byte_t i);
    for (int b = 7; b >= 0; b--)
    begin
      mosi = o[b];
      #62.5 sclk = 1'b1;
      i[b] = miso;
      #62.5 sclk = 1'b0;
    end
  endtask : xb
endmodule : bhci_host_spi

// ==== verification/testbench.sv ====
// Bench for the host control interface over SPI, then UART
// Assumes the SPI host model and the bound checker
`timescale 1ns/100ps
module testbench import bhci_pkg::*;;
  logic ref_clk, sys_rst, wake, pwr, rx_rdy, tx_vld, strap;
  logic [9:0] w;
  bhci_byte_t tx_d, rx_d, r0, r1, q[$];
  wire cs_n, sclk, mosi, miso, irq, drdy, st, rx_vld, tx_rdy, rts, oe;
  int fails, n_tests;
  bhci_top #(.BAUD_DIV_LO(16), .BAUD_DIV_HI(8)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .transport_select_strap(strap), .two_wire_clock_strap(1'b0),
    .wake_request_input(wake), .power_off_input(pwr), .cs_cts_in(cs_n), .clk_rts_in(sclk),
    .clk_rts_out(rts), .clk_rts_oe(oe),
    .mosi_rxd_in(mosi), .miso_txd_out(miso), .spi_irq_out(irq), .data_ready_irq_out(drdy),
    .state_out(st), .baud_div_in(17'h00000), .baud_div_load(1'b0), .host_rx_data(rx_d),
    .host_rx_valid(rx_vld), .host_rx_ready(rx_rdy), .host_tx_data(tx_d),
    .host_tx_valid(tx_vld), .host_tx_ready(tx_rdy));
  bhci_host_spi u_host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // Frame of a command and n data bytes; replies kept in q
  task frm(input bhci_byte_t c, input int n, input logic [11:0] v);
    q = {};
    u_host.open_f();
    u_host.xb(c, r0);
    for (int i = 0; i < n; i++)
    begin
      u_host.xb((n == 2) ? 8'(v >> (8 * i)) : 8'(i + 64), r0);
      q.push_back(r0);
    end
    u_host.close_f();
    {r1, r0} = {q[1], q[0]};
  endtask : frm
  task t_regs;
    frm(8'h25, 2, 12'h010);
    frm(8'h21, 2, 12'h3c5);
    frm(8'h05, 2, 12'h000);
    chk("enable", {r1, r0}, 16'h0010);
    frm(8'h01, 2, 12'h000);
    chk("threshold", {r1, r0}, 16'h03c5);
    frm(8'h0b, 2, 12'h000);
    chk("unmapped", {r1, r0}, 16'h0000);
  endtask : t_regs
  task t_rx;
    chk("irq_idle", irq, 16'h0000);
    frm(8'ha0, 32, 12'h000);
    frm(8'h27, 2, 12'h01f);
    frm(8'ha1, 1, 12'h000);
    chk("irq_set", irq, 16'h0001);
    frm(8'h09, 2, 12'h000);
    chk("rx_count", {r1, r0}, 16'h0800);
    frm(8'h03, 2, 12'h000);
    chk("status", {r1, r0}, 16'h001c);
    cyc(1);
    rx_rdy = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      chk("rx_byte", rx_d, 16'(i + 64));
      cyc(1);
    end
    rx_rdy = 1'b0;
    chk("rx_empty", rx_vld, 16'h0000);
    frm(8'h27, 2, 12'h010);
    chk("irq_clear", irq, 16'h0000);
  endtask : t_rx
  task t_tx;
    cyc(1);
    {tx_d, tx_vld} = {8'h3c, 1'b1};
    cyc(1);
    tx_d = 8'h81;
    cyc(1);
    tx_vld = 1'b0;
    cyc(3);
    chk("ready_low", drdy, 16'h0000);
    frm(8'h09, 2, 12'h000);
    chk("tx_count", {r1, r0}, 16'h0002);
    frm(8'h62, 2, 12'h000);
    chk("tx_bytes", {r1, r0}, 16'h813c);
    cyc(3);
    chk("ready_high", drdy, 16'h0001);
  endtask : t_tx
  task t_power;
    wake = 1'b0;
    cyc(10);
    chk("asleep", st, 16'h0000);
    u_host.open_f();
    cyc(6);
    chk("cs_wake", st, 16'h0001);
    u_host.close_f();
    cyc(6);
    chk("resleep", st, 16'h0000);
    wake = 1'b1;
    cyc(6);
    chk("awake", st, 16'h0001);
    pwr = 1'b0;
    cyc(10);
    wake = 1'b0;
    cyc(10);
    chk("frozen", st, 16'h0001);
  endtask : t_power
  // Second reset into UART mode: flow control and one 8N1 character
  task t_uart;
    {strap, sys_rst, wake, pwr} = 4'b0111;
    cyc(3);
    sys_rst = 1'b0;
    cyc(8);
    chk("rts_oe", oe, 16'h0001);
    chk("rts_low", rts, 16'h0000);
    {tx_d, tx_vld} = {8'ha5, 1'b1};
    cyc(1);
    tx_vld = 1'b0;
    cyc(40);
    chk("cts_hold", miso, 16'h0001);
    u_host.cs_n = 1'b0;
    @(negedge miso);
    cyc(8);
    for (int b = 0; b < 10; b++)
    begin
      w = {miso, w[9:1]};
      cyc(16);
    end
    chk("uart_char", w, 16'h034a);
  endtask : t_uart
  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    strap = 1'b1;
    {fails, n_tests, sys_rst, wake, pwr, rx_rdy, tx_vld, tx_d} = {64'd0, 5'b11100, 8'h00};
    cyc(3);
    sys_rst = 1'b0;
    cyc(8);
    t_regs();
    t_rx();
    t_tx();
    t_power();
    t_uart();
    report_and_stop();
  end
  initial
  begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule : testbench
